/* rtl/lsra_pkg.sv */
// constants and types for the light sensor range and alert block
//==================================================================
// Contract
// - range field value 1100b selects automatic full-scale ranging.
// - auto range starts with a 10 ms assessment choosing the first range.
// - later ranges follow last result: low drops one or two, high adds one.
// - overflowing conversion is dropped, reassessed for 10 ms, then repeated.
// - results compared to limits; reporting changes after N identical faults.
// - config bit 4 set means latched window, clear means transparent.
// - low limit top bits 11b select end-of-conversion reporting.
// - latched: above high or below low latches alert and matching flag.
// - latched: config read clears alert, high flag and low flag.
// - latched: finished alert response drops alert, keeps flags.
// - open-drain alert; polarity 0 pulls low active, 1 pulls low idle.
// - slave address is 1000100 plus the two-bit strap selection.
// - strap is sampled at every bus transaction start.
// - on address match, data line is pulled low in ninth clock.
// - clock line low for 28 ms resets the bus state machine.
// - every byte is shifted most significant bit first.
// - bus works at 100 kHz, 400 kHz and 2.6 MHz clock rates.
// - each byte is eight bits plus one acknowledge from the receiver.
// - config read clears conversion-ready right afterwards.
// - transparent: high fault sets high flag, alert; low fault the reverse.
// - transparent mode ignores and does not answer alert response.
package lsra_pkg;
  //==================================================================
  // timing
  localparam int CLK_HZ = 25000000;
  localparam int ASSESS_MS = 10;
  localparam int SHORT_MS = 100;
  localparam int LONG_MS = 800;
  localparam int TIMEOUT_MS = 28;
  localparam int ASSESS_CYC_DEF = CLK_HZ / 1000 * ASSESS_MS;
  localparam int SHORT_CYC_DEF = CLK_HZ / 1000 * SHORT_MS;
  localparam int LONG_CYC_DEF = CLK_HZ / 1000 * LONG_MS;
  localparam int TIMEOUT_CYC_DEF = CLK_HZ / 1000 * TIMEOUT_MS;
  //==================================================================
  // register indexes and fields
  localparam logic [7:0] REG_RESULT = 8'h00;
  localparam logic [7:0] REG_CONFIG = 8'h01;
  localparam logic [7:0] REG_LOW = 8'h02;
  localparam logic [7:0] REG_HIGH = 8'h03;
  localparam int CFG_RN_LO = 12;
  localparam int CFG_CT = 11;
  localparam int CFG_MODE_LO = 9;
  localparam int CFG_CRF = 7;
  localparam int CFG_FH = 6;
  localparam int CFG_FL = 5;
  localparam int CFG_LATCH = 4;
  localparam int CFG_POL = 3;
  localparam int CFG_FC_LO = 0;
  localparam logic [15:0] CFG_WMASK = 16'hfe1b;
  localparam logic [15:0] CFG_RST = 16'hc810;
  localparam logic [15:0] HIGH_RST = 16'hbfff;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] LOW_EOC = 2'h3;
  //==================================================================
  // ranging
  localparam logic [3:0] RN_AUTO = 4'hc;
  localparam logic [3:0] RN_MAX = 4'hb;
  localparam logic [11:0] MANT_MAX = 12'hfff;
  localparam logic [11:0] MANT_LOW2 = 12'h100;
  localparam logic [11:0] MANT_LOW1 = 12'h400;
  localparam logic [11:0] MANT_HIGH = 12'hc00;
  //==================================================================
  // bus addresses
  localparam logic [6:0] SLV_BASE = 7'h44;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_TXACK}
    lsra_bus_e;
  typedef enum logic [1:0] {C_IDLE, C_ASSESS, C_MEAS} lsra_conv_e;
endpackage

/* rtl/lsra_range_seq.sv */
// conversion timing and automatic range sequencer
`timescale 1ns/1ps
module lsra_range_seq #(
  parameter int ASSESS_CYC = lsra_pkg::ASSESS_CYC_DEF,
  parameter int SHORT_CYC = lsra_pkg::SHORT_CYC_DEF,
  parameter int LONG_CYC = lsra_pkg::LONG_CYC_DEF
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic ct_in,
  input wire logic [3:0] rn_in,
  input wire logic [22:0] light_in,
  output logic done_out,
  output logic [15:0] result_out
);
  typedef struct packed {
    lsra_pkg::lsra_conv_e st;
    logic [24:0] tmr;
    logic [3:0] rng;
    logic done;
    logic [15:0] res;
  } lsra_seq_s;
  lsra_seq_s s, n;
  logic [22:0] mant_w;
  logic ovf, auto_w;
  logic [24:0] meas_len;
  logic [3:0] rn_man;

  //==================================================================
  // range helpers
  function automatic logic [3:0] lsra_pick(input logic [22:0] l);
    lsra_pick = lsra_pkg::RN_MAX;
    for (int i = int'(lsra_pkg::RN_MAX); i >= 0; i--) begin
      if ((l >> i) <= 23'(lsra_pkg::MANT_MAX)) lsra_pick = 4'(i);
    end
  endfunction

  assign mant_w = light_in >> s.rng;
  assign ovf = |mant_w[22:12];
  assign auto_w = rn_in == lsra_pkg::RN_AUTO;
  assign meas_len = ct_in ? 25'(LONG_CYC - 1) : 25'(SHORT_CYC - 1);
  assign rn_man = (rn_in > lsra_pkg::RN_MAX) ? lsra_pkg::RN_MAX : rn_in;

  //==================================================================
  // sequencer
  always_comb begin
    n = s;
    n.done = 1'b0;
    unique case (s.st)
      lsra_pkg::C_IDLE: begin
        if (run_in) begin
          n.st = auto_w ? lsra_pkg::C_ASSESS : lsra_pkg::C_MEAS;
          n.tmr = auto_w ? 25'(ASSESS_CYC - 1) : meas_len;
          n.rng = auto_w ? s.rng : rn_man;
        end
      end
      lsra_pkg::C_ASSESS: begin
        if (!run_in) begin
          n.st = lsra_pkg::C_IDLE;
        end else if (s.tmr != '0) begin
          n.tmr = s.tmr - 25'd1;
        end else begin
          n.rng = lsra_pick(light_in);
          n.st = lsra_pkg::C_MEAS;
          n.tmr = meas_len;
        end
      end
      lsra_pkg::C_MEAS: begin
        if (!run_in) begin
          n.st = lsra_pkg::C_IDLE;
        end else if (s.tmr != '0) begin
          n.tmr = s.tmr - 25'd1;
        end else if (ovf && auto_w) begin
          n.st = lsra_pkg::C_ASSESS;
          n.tmr = 25'(ASSESS_CYC - 1);
        end else begin
          n.done = 1'b1;
          n.res = {s.rng, ovf ? lsra_pkg::MANT_MAX : mant_w[11:0]};
          n.tmr = meas_len;
          n.rng = rn_man;
          if (auto_w) begin
            n.rng = s.rng;
            if (mant_w[11:0] < lsra_pkg::MANT_LOW2 && s.rng > 4'h1) begin
              n.rng = s.rng - 4'h2;
            end else if (mant_w[11:0] < lsra_pkg::MANT_LOW1 &&
                         s.rng != 4'h0) begin
              n.rng = s.rng - 4'h1;
            end else if (mant_w[11:0] >= lsra_pkg::MANT_HIGH &&
                         s.rng < lsra_pkg::RN_MAX) begin
              n.rng = s.rng + 4'h1;
            end
          end
        end
      end
      default: n.st = lsra_pkg::C_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done_out = s.done;
  assign result_out = s.res;

  //==================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_assess_first;
    s.st == lsra_pkg::C_IDLE && run_in && auto_w |=>
      s.st == lsra_pkg::C_ASSESS && s.tmr == 25'(ASSESS_CYC - 1);
  endproperty
  a_assess_first: assert property (p_assess_first)
    else $error("auto range did not start with assessment");
  property p_abort;
    s.st == lsra_pkg::C_MEAS && s.tmr == '0 && run_in && auto_w && ovf
      |=> s.st == lsra_pkg::C_ASSESS && !done_out;
  endproperty
  a_abort: assert property (p_abort)
    else $error("overflowed conversion was reported");
endmodule // lsra_range_seq

/* rtl/lsra_top.sv */
// light sensor range, compare, alert and serial slave block
`timescale 1ns/1ps
module lsra_top #(
  parameter int ASSESS_CYC = lsra_pkg::ASSESS_CYC_DEF,
  parameter int SHORT_CYC = lsra_pkg::SHORT_CYC_DEF,
  parameter int LONG_CYC = lsra_pkg::LONG_CYC_DEF,
  parameter int TIMEOUT_CYC = lsra_pkg::TIMEOUT_CYC_DEF
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] addr_sel_in,
  output logic int_out,
  output logic int_oe_out,
  input wire logic [22:0] light_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out
);
  typedef struct packed {
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    logic [1:0] asel_m, asel_s;
    lsra_pkg::lsra_bus_e st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [1:0] bidx;
    logic rw, ara, sda_drv, hi_next, rd_pend;
    logic [6:0] slv;
    logic [7:0] ptr, wbuf;
    logic [15:0] txword;
    logic [23:0] tocnt;
    logic [15:0] cfg, low, high, rdata;
    logic int_act;
    logic [1:0] last;
    logic [3:0] fcnt;
  } lsra_top_s;
  lsra_top_s s, n;

  logic rise, fall, start, stop, to_hit;
  logic i2c_wr, i2c_rd, ara_done, alert_ok;
  logic acc_wr, acc_rd, cfg_rd, eoc, hi_f, lo_f, trig;
  logic [7:0] acc_addr;
  logic [15:0] acc_wdata, rd_mux;
  logic [1:0] oc;
  logic [3:0] newcnt, need;
  logic seq_done;
  logic [15:0] result_w;

  //==================================================================
  // helpers
  function automatic logic [26:0] lsra_lin(input logic [15:0] v);
    lsra_lin = 27'(v[11:0]) << v[15:12];
  endfunction

  //==================================================================
  // conversion sequencer
  lsra_range_seq #(
    .ASSESS_CYC(ASSESS_CYC),
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_seq (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .run_in(s.cfg[lsra_pkg::CFG_MODE_LO +: 2] != lsra_pkg::MODE_OFF),
    .ct_in(s.cfg[lsra_pkg::CFG_CT]),
    .rn_in(s.cfg[lsra_pkg::CFG_RN_LO +: 4]),
    .light_in(light_in),
    .done_out(seq_done),
    .result_out(result_w)
  );

  //==================================================================
  // bus line events
  assign rise = s.scl_s & ~s.scl_d;
  assign fall = ~s.scl_s & s.scl_d;
  assign start = s.scl_s & s.scl_d & s.sda_d & ~s.sda_s;
  assign stop = s.scl_s & s.scl_d & ~s.sda_d & s.sda_s;
  assign to_hit = ~s.scl_s && s.tocnt == 24'(TIMEOUT_CYC - 1);
  assign alert_ok = s.cfg[lsra_pkg::CFG_LATCH] & s.int_act;
  assign eoc = s.low[15:14] == lsra_pkg::LOW_EOC;
  assign hi_f = lsra_lin(result_w) > lsra_lin(s.high);
  assign lo_f = !eoc && lsra_lin(result_w) < lsra_lin(s.low);
  assign oc = {hi_f, lo_f};
  assign need = 4'h1 << s.cfg[lsra_pkg::CFG_FC_LO +: 2];

  always_comb begin
    case (acc_addr)
      lsra_pkg::REG_RESULT: rd_mux = result_w;
      lsra_pkg::REG_CONFIG: rd_mux = s.cfg;
      lsra_pkg::REG_LOW: rd_mux = s.low;
      lsra_pkg::REG_HIGH: rd_mux = s.high;
      default: rd_mux = '0;
    endcase
  end

  //==================================================================
  // serial slave and register file
  always_comb begin
    n = s;
    i2c_wr = 1'b0;
    i2c_rd = 1'b0;
    ara_done = 1'b0;
    n.scl_m = scl_in;
    n.scl_s = s.scl_m;
    n.scl_d = s.scl_s;
    n.sda_m = sda_in;
    n.sda_s = s.sda_m;
    n.sda_d = s.sda_s;
    n.asel_m = addr_sel_in;
    n.asel_s = s.asel_m;
    n.rd_pend = 1'b0;
    if (s.rd_pend) n.txword = s.rdata;
    n.tocnt = s.scl_s ? '0 : s.tocnt + 24'd1;
    if (to_hit) begin
      n.st = lsra_pkg::I_IDLE;
      n.sda_drv = 1'b0;
      n.tocnt = '0;
    end else if (start) begin
      n.st = lsra_pkg::I_ADDR;
      n.bitcnt = '0;
      n.sda_drv = 1'b0;
      n.slv = lsra_pkg::SLV_BASE | {5'h00, s.asel_s};
      n.ara = 1'b0;
    end else if (stop) begin
      n.st = lsra_pkg::I_IDLE;
      n.sda_drv = 1'b0;
    end else begin
      unique case (s.st)
        lsra_pkg::I_IDLE: n.sda_drv = 1'b0;
        lsra_pkg::I_ADDR, lsra_pkg::I_RX: begin
          if (rise && s.bitcnt != 4'h8) begin
            n.shreg = {s.shreg[6:0], s.sda_s};
            n.bitcnt = s.bitcnt + 4'h1;
          end else if (fall && s.bitcnt == 4'h8) begin
            n.st = lsra_pkg::I_ACK;
            n.sda_drv = 1'b1;
            if (s.st == lsra_pkg::I_ADDR) begin
              n.rw = s.shreg[0];
              n.bidx = '0;
              n.hi_next = 1'b1;
              n.ara = s.shreg[7:1] == lsra_pkg::ARA_ADDR && s.shreg[0] &&
                      alert_ok;
              if (n.ara) begin
                n.txword = {s.slv, 1'b0, s.slv, 1'b0};
              end else if (s.shreg[7:1] != s.slv) begin
                n.st = lsra_pkg::I_IDLE;
                n.sda_drv = 1'b0;
              end else if (s.shreg[0]) begin
                i2c_rd = 1'b1;
                n.rd_pend = 1'b1;
              end
            end else if (s.bidx == 2'h0) begin
              n.ptr = s.shreg;
              n.bidx = 2'h1;
            end else if (s.bidx == 2'h1) begin
              n.wbuf = s.shreg;
              n.bidx = 2'h2;
            end else begin
              i2c_wr = 1'b1;
              n.bidx = 2'h1;
            end
          end
        end
        lsra_pkg::I_ACK: begin
          if (fall) begin
            n.bitcnt = '0;
            if (s.rw) begin
              n.st = lsra_pkg::I_TX;
              n.shreg = s.hi_next ? s.txword[15:8] : s.txword[7:0];
              n.sda_drv = s.hi_next ? ~s.txword[15] : ~s.txword[7];
              n.hi_next = ~s.hi_next;
            end else begin
              n.st = lsra_pkg::I_RX;
              n.sda_drv = 1'b0;
            end
          end
        end
        lsra_pkg::I_TX: begin
          if (fall) begin
            n.bitcnt = s.bitcnt + 4'h1;
            n.shreg = {s.shreg[6:0], 1'b0};
            n.sda_drv = ~s.shreg[6];
            if (s.bitcnt == 4'h7) begin
              n.st = lsra_pkg::I_TXACK;
              n.sda_drv = 1'b0;
            end
          end
        end
        lsra_pkg::I_TXACK: begin
          if (rise) begin
            if (s.ara) begin
              ara_done = 1'b1;
              n.st = lsra_pkg::I_IDLE;
            end else if (s.sda_s) begin
              n.st = lsra_pkg::I_IDLE;
            end else begin
              n.st = lsra_pkg::I_ACK;
            end
          end
        end
        default: n.st = lsra_pkg::I_IDLE;
      endcase
    end

    acc_wr = reg_wr_in | i2c_wr;
    acc_rd = reg_rd_in | i2c_rd;
    acc_addr = (reg_wr_in | reg_rd_in) ? reg_addr_in : s.ptr;
    acc_wdata = reg_wr_in ? reg_wdata_in : {s.wbuf, s.shreg};
    cfg_rd = acc_rd && acc_addr == lsra_pkg::REG_CONFIG;
    if (acc_rd) n.rdata = rd_mux;
    if (acc_wr) begin
      case (acc_addr)
        lsra_pkg::REG_CONFIG: begin
          n.cfg = (acc_wdata & lsra_pkg::CFG_WMASK) |
                  (s.cfg & ~lsra_pkg::CFG_WMASK);
          if (acc_wdata[lsra_pkg::CFG_MODE_LO +: 2] != lsra_pkg::MODE_OFF)
            n.cfg[lsra_pkg::CFG_CRF] = 1'b0;
        end
        lsra_pkg::REG_LOW: n.low = acc_wdata;
        lsra_pkg::REG_HIGH: n.high = acc_wdata;
        default: n.low = s.low;
      endcase
    end
    if (cfg_rd) begin
      n.cfg[lsra_pkg::CFG_CRF] = 1'b0;
      if (s.cfg[lsra_pkg::CFG_LATCH] || eoc) n.int_act = 1'b0;
      if (s.cfg[lsra_pkg::CFG_LATCH]) begin
        n.cfg[lsra_pkg::CFG_FH] = 1'b0;
        n.cfg[lsra_pkg::CFG_FL] = 1'b0;
      end
    end
    if (ara_done && s.cfg[lsra_pkg::CFG_LATCH]) n.int_act = 1'b0;

    newcnt = (oc == s.last && s.fcnt != 4'hf) ? s.fcnt + 4'h1 :
             (oc == s.last) ? s.fcnt : 4'h1;
    trig = seq_done && oc != 2'h0 && newcnt >= need;
    if (seq_done) begin
      n.cfg[lsra_pkg::CFG_CRF] = 1'b1;
      if (s.cfg[lsra_pkg::CFG_MODE_LO +: 2] == lsra_pkg::MODE_SINGLE)
        n.cfg[lsra_pkg::CFG_MODE_LO +: 2] = lsra_pkg::MODE_OFF;
      n.last = oc;
      n.fcnt = newcnt;
      if (eoc) n.int_act = 1'b1;
    end
    if (trig) begin
      if (s.cfg[lsra_pkg::CFG_LATCH]) begin
        n.int_act = 1'b1;
        if (hi_f) n.cfg[lsra_pkg::CFG_FH] = 1'b1;
        if (lo_f) n.cfg[lsra_pkg::CFG_FL] = 1'b1;
      end else begin
        n.cfg[lsra_pkg::CFG_FH] = hi_f;
        n.cfg[lsra_pkg::CFG_FL] = ~hi_f;
        n.int_act = eoc ? n.int_act : hi_f;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.cfg <= lsra_pkg::CFG_RST;
      s.high <= lsra_pkg::HIGH_RST;
    end else begin
      s <= n;
    end
  end

  //==================================================================
  // pins
  assign sda_out = 1'b0;
  assign sda_oe_out = s.sda_drv;
  assign int_out = 1'b0;
  assign int_oe_out = s.cfg[lsra_pkg::CFG_POL] ? ~s.int_act :
                      s.int_act;
  assign reg_rdata_out = s.rdata;

  //==================================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_addr_match;
    s.st == lsra_pkg::I_ADDR && fall && !start && !stop && !to_hit &&
      s.bitcnt == 4'h8 && s.shreg[7:1] == s.slv;
  endsequence
  property p_addr_ack;
    s_addr_match |=> sda_oe_out && s.st == lsra_pkg::I_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matching address not acknowledged");
  property p_crf_clear;
    cfg_rd && !seq_done |=> !s.cfg[lsra_pkg::CFG_CRF];
  endproperty
  a_crf_clear: assert property (p_crf_clear)
    else $error("conversion ready not cleared by config read");
  property p_latch_clear;
    cfg_rd && s.cfg[lsra_pkg::CFG_LATCH] && !seq_done |=>
      !s.int_act && !s.cfg[lsra_pkg::CFG_FH] && !s.cfg[lsra_pkg::CFG_FL];
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("latched alert survived config read");
  property p_ara;
    ara_done && s.cfg[lsra_pkg::CFG_LATCH] && !seq_done && !cfg_rd |=>
      !s.int_act && $stable(s.cfg[lsra_pkg::CFG_FH]) &&
      $stable(s.cfg[lsra_pkg::CFG_FL]);
  endproperty
  a_ara: assert property (p_ara)
    else $error("alert response handling wrong");
  property p_pol;
    !s.cfg[lsra_pkg::CFG_POL] |-> int_oe_out == s.int_act;
  endproperty
  a_pol: assert property (p_pol)
    else $error("alert pin polarity wrong");
  property p_timeout;
    to_hit |=> s.st == lsra_pkg::I_IDLE && !sda_oe_out;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("bus not reset after clock low timeout");
  property p_transp_hi;
    trig && hi_f && !s.cfg[lsra_pkg::CFG_LATCH] && !eoc |=>
      s.cfg[lsra_pkg::CFG_FH] && !s.cfg[lsra_pkg::CFG_FL] && s.int_act;
  endproperty
  a_transp_hi: assert property (p_transp_hi)
    else $error("transparent high fault not reported");
  property p_restart;
    seq_done && oc != s.last |=> s.fcnt == 4'h1;
  endproperty
  a_restart: assert property (p_restart)
    else $error("fault counter did not restart");
  property p_no_ara_transp;
    s.st == lsra_pkg::I_ADDR && !s.cfg[lsra_pkg::CFG_LATCH] |=> !s.ara;
  endproperty
  a_no_ara_transp: assert property (p_no_ara_transp)
    else $error("alert response answered in transparent mode");
endmodule // lsra_top

/* dv/lsra_i2c_master.sv */
// serial bus master model facing the light sensor block
`timescale 1ns/1ps
module lsra_i2c_master (
  output logic scl_out,
  output logic sda_low_out,
  input wire logic sda_in
);
  //==================================================================
  // idle bus, clock stands high outside frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  //==================================================================
  // frame conditions
  task automatic start();
    #5;
    sda_low_out = 1'b0;
    scl_out = 1'b1;
    #80 sda_low_out = 1'b1;
    #80 scl_out = 1'b0;
    #80;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #80 scl_out = 1'b1;
    #80 sda_low_out = 1'b0;
    #80;
  endtask
  //==================================================================
  // bits and bytes, 320 ns clock period
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    #80 scl_out = 1'b1;
    #80 r = sda_in;
    #80 scl_out = 1'b0;
    #80;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule // lsra_i2c_master

/* dv/lsra_bench.sv */
// self-checking bench for the light sensor block
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  miscompares++; $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module lsra_bench;
  logic clk_in, rst_n_in, sda_out, sda_oe_out, int_out, int_oe_out;
  logic scl, sda_low, reg_wr, reg_rd, ack;
  logic [1:0] addr_sel;
  logic [22:0] light;
  logic [7:0] reg_addr, b0, b1;
  logic [15:0] reg_wdata, reg_rdata, d;
  int miscompares = 0;
  int comparisons = 0;
  int cyc = 0;
  wire sda = (sda_low | sda_oe_out) ? 1'b0 : 1'b1;
  lsra_top #(.ASSESS_CYC(20), .SHORT_CYC(40), .LONG_CYC(80),
    .TIMEOUT_CYC(200)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .addr_sel_in(addr_sel), .int_out(int_out),
    .int_oe_out(int_oe_out), .light_in(light), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(reg_rdata));
  lsra_i2c_master m (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda));
  //==================================================================
  // clock, hang limit, verdict
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  //==================================================================
  // access tasks
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_in);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic i2w(input logic [7:0] p, input logic [15:0] v);
    m.start();
    m.send({lsra_pkg::SLV_BASE | {5'h0, addr_sel}, 1'b0}, ack);
    `CHK(ack, 1'b1)
    m.send(p, ack);
    m.send(v[15:8], ack);
    m.send(v[7:0], ack);
    m.stop();
  endtask
  task automatic ara(output logic a);
    m.start();
    m.send({lsra_pkg::ARA_ADDR, 1'b1}, a);
    if (a === 1'b1) begin
      m.recv(1'b1, b0);
    end
    m.stop();
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  //==================================================================
  // tests
  initial begin
    rst_n_in = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    addr_sel = 2'h0;
    light = 23'h000000;
    waitc(4);
    rst_n_in <= 1'b1;
    waitc(3);
    rd(lsra_pkg::REG_CONFIG, d);
    `CHK(d, 16'hc810)
    rd(lsra_pkg::REG_HIGH, d);
    `CHK(d, 16'hbfff)
    rd(8'h07, d);
    `CHK(d, 16'h0000)
    for (int i = 0; i < 4; i++) begin
      addr_sel <= 2'(i);
      waitc(3);
      i2w(lsra_pkg::REG_HIGH, {8'h12, 6'h00, 2'(i)});
      rd(lsra_pkg::REG_HIGH, d);
      `CHK(d, {8'h12, 6'h00, 2'(i)})
    end
    m.start();
    m.send({lsra_pkg::SLV_BASE, 1'b0}, ack);
    `CHK(ack, 1'b0)
    m.stop();
    m.start();
    m.send({lsra_pkg::SLV_BASE | 7'h03, 1'b1}, ack);
    m.recv(1'b0, b0);
    m.recv(1'b1, b1);
    m.stop();
    `CHK({b0, b1}, 16'h1203)
    i2w(lsra_pkg::REG_LOW, 16'h0000);
    m.start();
    m.send({lsra_pkg::SLV_BASE | 7'h03, 1'b1}, ack);
    #200;
    `CHK(sda_oe_out, 1'b1)
    #10000;
    `CHK(sda_oe_out, 1'b0)
    m.stop();
    wr(lsra_pkg::REG_HIGH, 16'h0100);
    wr(lsra_pkg::REG_LOW, 16'h0010);
    light <= 23'h000200;
    wr(lsra_pkg::REG_CONFIG, 16'h0210);
    waitc(100);
    `CHK(int_oe_out, 1'b1)
    rd(lsra_pkg::REG_RESULT, d);
    `CHK(d, 16'h0200)
    ara(ack);
    `CHK(ack, 1'b1)
    `CHK(b0, {lsra_pkg::SLV_BASE | 7'h03, 1'b0})
    `CHK(int_oe_out, 1'b0)
    rd(lsra_pkg::REG_CONFIG, d);
    `CHK(d[7:5], 3'h6)
    rd(lsra_pkg::REG_CONFIG, d);
    `CHK(d[7:5], 3'h0)
    light <= 23'h000008;
    wr(lsra_pkg::REG_CONFIG, 16'h0210);
    waitc(100);
    `CHK(int_oe_out, 1'b1)
    rd(lsra_pkg::REG_CONFIG, d);
    `CHK(d[6:5], 2'h1)
    waitc(2);
    `CHK(int_oe_out, 1'b0)
    light <= 23'h000200;
    wr(lsra_pkg::REG_CONFIG, 16'h0400);
    waitc(100);
    `CHK(int_oe_out, 1'b1)
    rd(lsra_pkg::REG_CONFIG, d);
    `CHK(d[6:5], 2'h2)
    ara(ack);
    `CHK(ack, 1'b0)
    `CHK(int_oe_out, 1'b1)
    light <= 23'h000008;
    waitc(100);
    `CHK(int_oe_out, 1'b0)
    rd(lsra_pkg::REG_CONFIG, d);
    `CHK(d[6:5], 2'h1)
    wr(lsra_pkg::REG_CONFIG, 16'h0408);
    waitc(100);
    `CHK(int_oe_out, 1'b1)
    light <= 23'h000200;
    waitc(100);
    `CHK(int_oe_out, 1'b0)
    wr(lsra_pkg::REG_CONFIG, 16'h0403);
    light <= 23'h000008;
    waitc(80);
    light <= 23'h000200;
    waitc(80);
    light <= 23'h000008;
    waitc(150);
    `CHK(int_oe_out, 1'b1)
    waitc(300);
    `CHK(int_oe_out, 1'b0)
    light <= 23'h0e0000;
    wr(lsra_pkg::REG_CONFIG, 16'hc400);
    waitc(600);
    rd(lsra_pkg::REG_RESULT, d);
    `CHK(d, 16'h9700)
    light <= 23'h7fffff;
    waitc(600);
    rd(lsra_pkg::REG_RESULT, d);
    `CHK(d, 16'hbfff)
    wr(lsra_pkg::REG_CONFIG, 16'hc000);
    wr(lsra_pkg::REG_HIGH, 16'hbfff);
    wr(lsra_pkg::REG_LOW, 16'hc000);
    rd(lsra_pkg::REG_CONFIG, d);
    `CHK(int_oe_out, 1'b0)
    wr(lsra_pkg::REG_CONFIG, 16'hc200);
    waitc(100);
    `CHK(int_oe_out, 1'b1)
    `CHK({int_out, sda_out}, 2'h0)
    final_report();
  end
endmodule // lsra_bench
